/* core/second_stage_speed_switch.sv */
// second ignition stage: spark, speed or fault switching and its menu
// Summary of operation
// - modes 1/2 fire stage zero or half-turn offset
// - mode 3 switches on speed thresholds only
// - mode 4 holds output on during fault
// - mode 5 blinks output during fault
// - switching modes only in single-cylinder operation
// - ground output above lower speed threshold
// - release output above upper speed threshold
// - switching output updated every 0.2 seconds
// - thresholds stored in 100 rpm units
// - reject bad thresholds, show error, keep old
// - offer mode values, 3 s each, take on press
// - show current lower then upper threshold
// - offer lower then upper threshold, 3 s each
// - enter digits: 0-5, 0-9, 0-9, 3 s each
// - second threshold edited only if pressed in time
// - commit valid values, show stored, return
`timescale 1ns/1ps
`include "sss_consts.svh"
module second_stage_speed_switch
  import sss_pkg::*;
#(
  parameter int unsigned STEP_CYCLES   = `SSS_STEP_CYCLES,
  parameter int unsigned UPDATE_CYCLES = `SSS_UPDATE_CYCLES
)(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // axi4-lite register slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // engine side, same clock
  input  wire logic [15:0] engine_rpm,
  input  wire logic        fault_present,
  input  wire logic        spark_zero,
  input  wire logic        spark_half,
  // user side
  input  wire logic        magnet_pin,
  output disp_s            display,
  // second stage open-drain pin
  input  wire logic        stage_i,
  output logic             stage_o,
  output logic             stage_oe_n,
  // interrupt
  output logic             irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic        wstrb0;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        single;
    logic [2:0]  mode;
    logic [9:0]  lo;
    logic [9:0]  hi;
    logic [2:0]  ist;
    logic [2:0]  imask;
    logic        irq;
    menu_e       ms;
    logic [31:0] cnt;
    logic        phase;
    logic [3:0]  cand;
    logic [1:0]  didx;
    logic [9:0]  acc;
    logic        sel_hi;
    logic [9:0]  elo;
    logic [9:0]  ehi;
    logic [31:0] tcnt;
    logic        on;
    logic        drive_n;
    disp_s       disp;
  } state_s;

  state_s      q;
  state_s      d;
  logic        press;
  logic        stage_lvl;
  logic        tick;
  logic        step;
  logic        valid;
  logic        menu_go;
  logic [2:0]  ist_set;
  logic [2:0]  ist_clr;
  logic [16:0] spd;
  logic [16:0] lo_rpm;
  logic [16:0] hi_rpm;
  logic [2:0]  mode_low;
  logic [2:0]  mode_top;
  logic [9:0]  acc_new;
  logic [11:0] shown;
  logic [31:0] rd;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  magnet_sync u_magnet (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (magnet_pin),
    .level (),
    .rise  (press)
  );

  magnet_sync u_stage (
    .clock (clock),
    .rst_n (rst_n),
    .pin   (stage_i),
    .level (stage_lvl),
    .rise  ()
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic reg_e reg_sel(input logic [7:0] a);
    unique case (a)
      `SSS_OFS_CTRL:     return R_CTRL;
      `SSS_OFS_MODE:     return R_MODE;
      `SSS_OFS_THRESH:   return R_THR;
      `SSS_OFS_STATUS:   return R_STAT;
      `SSS_OFS_IRQ_STAT: return R_ISTAT;
      `SSS_OFS_IRQ_MASK: return R_IMASK;
      default:           return R_NONE;
    endcase
  endfunction

  // switching modes need the stage free of ignition duty
  function automatic logic mode_ok(input logic [2:0] m, input logic single);
    return (m >= `SSS_MODE_BOXER) && (m <= `SSS_MODE_BLINK) &&
           (single || m < `SSS_MODE_SPEED);
  endfunction

  function automatic logic [11:0] digits_of(input logic [9:0] v);
    return {4'(v / 10'h064), 4'((v / 10'h00A) % 10'h00A), 4'(v % 10'h00A)};
  endfunction

  assign spd      = {1'b0, engine_rpm};
  assign lo_rpm   = {7'h00, q.lo} * `SSS_RPM_UNIT;
  assign hi_rpm   = {7'h00, q.hi} * `SSS_RPM_UNIT;
  assign tick     = (q.tcnt == 32'(UPDATE_CYCLES - 1));
  assign step     = (q.cnt == 32'(STEP_CYCLES - 1));
  assign valid    = (q.elo != 10'h000) && (q.elo < q.ehi) &&
                    (q.ehi < `SSS_THR_LIMIT);
  assign mode_low = q.single ? `SSS_MODE_SPEED : `SSS_MODE_BOXER;
  assign mode_top = q.single ? `SSS_MODE_BLINK : `SSS_MODE_TWIN;
  assign acc_new  = 10'(q.acc * 10'h00A) + {6'h00, q.cand};

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    d       = q;
    menu_go = 1'b0;
    ist_set = 3'h0;
    ist_clr = 3'h0;
    rd      = 32'h0000_0000;
    // write channel: address and data in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_got  = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      d.bvalid = 1'b1;
      d.bresp  = (reg_sel(q.awaddr) == R_NONE) ? `SSS_RESP_SLVERR : `SSS_RESP_OKAY;
      if (q.wstrb0) begin
        unique case (reg_sel(q.awaddr))
          R_CTRL: begin
            d.single = q.wdata[`SSS_CTRL_SINGLE_BIT];
            menu_go  = q.wdata[`SSS_CTRL_MENU_BIT];
          end
          R_MODE: begin
            if (mode_ok(q.wdata[2:0], q.single)) begin
              d.mode = q.wdata[2:0];
            end
          end
          R_ISTAT: ist_clr = q.wdata[2:0];
          R_IMASK: d.imask = q.wdata[2:0];
          default: ;
        endcase
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
    end
    d.awready = ~d.aw_got;
    d.wready  = ~d.w_got;
    // read channel
    unique case (reg_sel(s_axi_araddr))
      R_CTRL:  rd = {30'h0, 1'b0, q.single};
      R_MODE:  rd = {29'h0, q.mode};
      R_THR:   rd = {6'h00, q.hi, 6'h00, q.lo};
      R_STAT:  rd = {29'h0, stage_lvl, q.ms != M_IDLE, q.on};
      R_ISTAT: rd = {29'h0, q.ist};
      R_IMASK: rd = {29'h0, q.imask};
      default: rd = 32'h0000_0000;
    endcase
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = (reg_sel(s_axi_araddr) == R_NONE) ? `SSS_RESP_SLVERR : `SSS_RESP_OKAY;
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.arready = ~d.rvalid;

    // stage output; switching decisions only on the slow tick
    d.tcnt = tick ? 32'h0000_0000 : q.tcnt + 32'h0000_0001;
    if (q.mode == `SSS_MODE_BOXER) begin
      d.on = spark_zero;
    end else if (q.mode == `SSS_MODE_TWIN) begin
      d.on = spark_half;
    end else if (tick) begin
      if (!q.single) begin
        d.on = 1'b0;
      end else if (q.mode == `SSS_MODE_SPEED) begin
        d.on = (spd > lo_rpm) && !(spd > hi_rpm);
      end else if (q.mode == `SSS_MODE_STEADY) begin
        d.on = fault_present;
      end else begin
        d.on = fault_present && !q.on;
      end
      ist_set[`SSS_EV_OUT_CHANGE] = (d.on != q.on);
    end
    d.drive_n = ~d.on;

    // menu; every transition but the one out of M_CHECK lands on a step, a press or the menu start, so cnt restarts
    d.cnt = (step || press) ? 32'h0000_0000 : q.cnt + 32'h0000_0001;
    unique case (q.ms)
      M_IDLE: begin
        if (menu_go) begin
          d.ms  = M_SHOWMODE;
          d.cnt = 32'h0000_0000;
        end
      end
      M_SHOWMODE: begin
        if (step) begin
          d.ms   = M_OFFERMODE;
          d.cand = {1'b0, mode_low};
        end
      end
      M_OFFERMODE: begin
        if (press) begin
          d.mode = q.cand[2:0];
          if (q.cand[2:0] == `SSS_MODE_SPEED) begin
            d.ms     = M_SHOWTHR;
            d.phase  = 1'b0;
            d.sel_hi = 1'b0;
          end else begin
            d.ms                     = M_STORED;
            ist_set[`SSS_EV_STORED]  = 1'b1;
          end
        end else if (step) begin
          d.cand = (q.cand[2:0] == mode_top) ? {1'b0, mode_low} : q.cand + 4'h1;
        end
      end
      M_SHOWTHR: begin
        if (step) begin
          d.phase = ~q.phase;
          if (q.phase) begin
            d.sel_hi = 1'b1;
            if (q.sel_hi) begin
              d.ms = M_READY;
            end
          end
        end
      end
      M_READY: begin
        if (step) begin
          d.ms     = M_OFFER;
          d.sel_hi = 1'b0;
          d.elo    = q.lo;
          d.ehi    = q.hi;
        end
      end
      M_OFFER: begin
        if (press) begin
          d.ms   = M_DIGIT;
          d.didx = 2'h0;
          d.cand = 4'h0;
          d.acc  = 10'h000;
        end else if (step) begin
          // an offer that runs out leaves that threshold as it was
          if (q.sel_hi) begin
            d.ms = M_CHECK;
          end else begin
            d.sel_hi = 1'b1;
          end
        end
      end
      M_DIGIT: begin
        if (press) begin
          d.cand = 4'h0;
          d.acc  = acc_new;
          d.didx = q.didx + 2'h1;
          if (q.didx == `SSS_LAST_DIGIT) begin
            if (q.sel_hi) begin
              d.ehi = acc_new;
              d.ms  = M_CHECK;
            end else begin
              d.elo    = acc_new;
              d.sel_hi = 1'b1;
              d.ms     = M_OFFER;
            end
          end
        end else if (step) begin
          if (q.cand == ((q.didx == 2'h0) ? `SSS_TOP_DIGIT_MAX : `SSS_DIGIT_MAX)) begin
            d.cand = 4'h0;
          end else begin
            d.cand = q.cand + 4'h1;
          end
        end
      end
      M_CHECK: begin
        if (valid) begin
          d.lo                    = q.elo;
          d.hi                    = q.ehi;
          d.ms                    = M_STORED;
          ist_set[`SSS_EV_STORED] = 1'b1;
        end else begin
          d.ms                       = M_ERR;
          ist_set[`SSS_EV_ENTRY_ERR] = 1'b1;
        end
      end
      M_STORED, M_ERR: begin
        if (step) begin
          d.ms = M_IDLE;
        end
      end
    endcase

    // display follows the state it is entering
    d.disp = '{kind: DK_BLANK, tens: 4'h0, ones: 4'h0};
    shown  = digits_of(d.sel_hi ? d.hi : d.lo);
    unique case (d.ms)
      M_IDLE:      d.disp.kind = DK_BLANK;
      M_SHOWMODE:  d.disp = '{kind: DK_MODE, tens: 4'h0, ones: {1'b0, d.mode}};
      M_OFFERMODE: d.disp = '{kind: DK_MODE, tens: 4'h0, ones: d.cand};
      M_SHOWTHR:   d.disp = d.phase ?
                     '{kind: DK_DIGITS, tens: shown[3:0], ones: 4'h0} :
                     '{kind: DK_DIGITS, tens: shown[11:8], ones: shown[7:4]};
      M_READY:     d.disp.kind = DK_READY;
      M_OFFER:     d.disp = '{kind: DK_SELECT, tens: 4'h0, ones: {3'h0, d.sel_hi}};
      M_DIGIT:     d.disp = '{kind: DK_DIGITS, tens: {2'h0, d.didx}, ones: d.cand};
      M_CHECK:     d.disp.kind = DK_BLANK;
      M_STORED:    d.disp.kind = DK_STORED;
      M_ERR:       d.disp.kind = DK_ERROR;
    endcase

    // sticky events: a set in the clearing cycle survives
    d.ist = (q.ist & ~ist_clr) | ist_set;
    d.irq = |(d.ist & d.imask);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.single  <= `SSS_RST_SINGLE;
      q.mode    <= `SSS_RST_MODE;
      q.lo      <= `SSS_RST_LO;
      q.hi      <= `SSS_RST_HI;
      q.drive_n <= 1'b1;
      q.ms      <= M_IDLE;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign display       = q.disp;
  assign stage_o       = 1'b0;
  assign stage_oe_n    = q.drive_n;
  assign irq           = q.irq;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_speed_on;
    @(posedge clock) disable iff (!rst_n)
    (tick && q.single && q.mode == `SSS_MODE_SPEED && spd > lo_rpm && !(spd > hi_rpm))
      |=> (q.on && !stage_oe_n);
  endproperty
  a_speed_on: assert property (p_speed_on) else $error("not grounded above lower");

  property p_speed_upper;
    @(posedge clock) disable iff (!rst_n)
    (tick && q.mode == `SSS_MODE_SPEED && spd > hi_rpm) |=> (!q.on && stage_oe_n);
  endproperty
  a_speed_upper: assert property (p_speed_upper) else $error("driven above upper");

  property p_speed_below;
    @(posedge clock) disable iff (!rst_n)
    (tick && q.mode == `SSS_MODE_SPEED && !(spd > lo_rpm)) |=> stage_oe_n;
  endproperty
  a_speed_below: assert property (p_speed_below) else $error("driven below lower");

  property p_update_hold;
    @(posedge clock) disable iff (!rst_n)
    (!tick && q.mode >= `SSS_MODE_SPEED) ##1 (q.mode >= `SSS_MODE_SPEED) |-> $stable(q.on);
  endproperty
  a_update_hold: assert property (p_update_hold) else $error("output moved off tick");

  property p_steady;
    @(posedge clock) disable iff (!rst_n)
    (tick && q.single && q.mode == `SSS_MODE_STEADY) |=> (q.on == $past(fault_present));
  endproperty
  a_steady: assert property (p_steady) else $error("steady output wrong");

  property p_blink;
    @(posedge clock) disable iff (!rst_n)
    (tick && q.single && q.mode == `SSS_MODE_BLINK && fault_present) |=> (q.on != $past(q.on));
  endproperty
  a_blink: assert property (p_blink) else $error("blink did not toggle");

  property p_multi_off;
    @(posedge clock) disable iff (!rst_n)
    (tick && !q.single && q.mode >= `SSS_MODE_SPEED) |=> !q.on;
  endproperty
  a_multi_off: assert property (p_multi_off) else $error("switching in multi-cyl");

  property p_reject;
    @(posedge clock) disable iff (!rst_n)
    (q.ms == M_CHECK && !valid) |=> (q.ms == M_ERR && $stable(q.lo) && $stable(q.hi)
      && q.disp.kind == DK_ERROR && q.ist[`SSS_EV_ENTRY_ERR]);
  endproperty
  a_reject: assert property (p_reject) else $error("bad entry not rejected");

  property p_commit;
    @(posedge clock) disable iff (!rst_n)
    (q.ms == M_CHECK && valid) |=> (q.lo == $past(q.elo) && q.hi == $past(q.ehi)
      && q.ms == M_STORED && q.disp.kind == DK_STORED);
  endproperty
  a_commit: assert property (p_commit) else $error("valid entry not stored");

  property p_digit_wrap;
    @(posedge clock) disable iff (!rst_n)
    (q.ms == M_DIGIT && q.didx == 2'h0 && q.cand == `SSS_TOP_DIGIT_MAX && step && !press)
      |=> (q.cand == 4'h0 && q.ms == M_DIGIT);
  endproperty
  a_digit_wrap: assert property (p_digit_wrap) else $error("top digit wrap wrong");
endmodule // second_stage_speed_switch

/* shared/sss_consts.svh */
// constants of the second ignition stage controller
`ifndef SSS_CONSTS_SVH
`define SSS_CONSTS_SVH
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define SSS_CLK_HZ          25000000
`define SSS_STEP_MS         3000
`define SSS_UPDATE_MS       200
`define SSS_STEP_CYCLES     (`SSS_CLK_HZ / 1000 * `SSS_STEP_MS)
`define SSS_UPDATE_CYCLES   (`SSS_CLK_HZ / 1000 * `SSS_UPDATE_MS)
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SSS_OFS_CTRL        8'h00
`define SSS_OFS_MODE        8'h04
`define SSS_OFS_THRESH      8'h08
`define SSS_OFS_STATUS      8'h0C
`define SSS_OFS_IRQ_STAT    8'h10
`define SSS_OFS_IRQ_MASK    8'h14
// -----------------------------------------------------------------
// fields and values
// -----------------------------------------------------------------
`define SSS_CTRL_SINGLE_BIT 0
`define SSS_CTRL_MENU_BIT   1
`define SSS_THR_HI_LSB      16
`define SSS_EV_STORED       0
`define SSS_EV_ENTRY_ERR    1
`define SSS_EV_OUT_CHANGE   2
`define SSS_MODE_BOXER      3'h1
`define SSS_MODE_TWIN       3'h2
`define SSS_MODE_SPEED      3'h3
`define SSS_MODE_STEADY     3'h4
`define SSS_MODE_BLINK      3'h5
`define SSS_RST_MODE        3'h5
`define SSS_RST_SINGLE      1'h1
`define SSS_RST_LO          10'h032
`define SSS_RST_HI          10'h064
`define SSS_THR_LIMIT       10'h257
`define SSS_RPM_UNIT        17'h00064
`define SSS_TOP_DIGIT_MAX   4'h5
`define SSS_DIGIT_MAX       4'h9
`define SSS_LAST_DIGIT      2'h2
`define SSS_RESP_OKAY       2'h0
`define SSS_RESP_SLVERR     2'h2
`endif

/* shared/sss_pkg.sv */
// types of the second ignition stage controller
package sss_pkg;
  typedef enum logic [3:0] {
    M_IDLE, M_SHOWMODE, M_OFFERMODE, M_SHOWTHR, M_READY,
    M_OFFER, M_DIGIT, M_CHECK, M_STORED, M_ERR
  } menu_e;
  typedef enum logic [2:0] {
    DK_BLANK, DK_MODE, DK_DIGITS, DK_READY, DK_SELECT, DK_ERROR, DK_STORED
  } disp_e;
  typedef enum logic [2:0] {
    R_CTRL, R_MODE, R_THR, R_STAT, R_ISTAT, R_IMASK, R_NONE
  } reg_e;
  typedef struct packed {
    disp_e      kind;
    logic [3:0] tens;
    logic [3:0] ones;
  } disp_s;
  typedef struct packed {
    logic [2:0] ff;
    logic       level;
    logic       rise;
  } sync_s;
endpackage

/* core/magnet_sync.sv */
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module magnet_sync
  import sss_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // pin side
  input  wire logic pin,
  // clean side
  output logic      level,
  output logic      rise
);
  sync_s q;
  sync_s d;

  always_comb begin
    d       = q;
    d.ff    = {q.ff[1:0], pin};
    // ff[0] feeds ff[1] only; a change counts once ff[1] and ff[2] agree
    if (q.ff[1] == q.ff[2]) begin
      d.level = q.ff[2];
    end
    d.rise  = d.level & ~q.level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.level;
  assign rise  = q.rise;
endmodule // magnet_sync

/* sim/load_model.sv */
// external load from battery to the open-drain second stage pin
`timescale 1ns/1ps
module load_model (
  // pin side
  input  wire logic stage_o,
  input  wire logic stage_oe_n,
  // level seen on the wire
  output logic      pin_level
);
  // released pin is pulled up to battery through the load
  assign pin_level = stage_oe_n ? 1'h1 : stage_o;
endmodule // load_model

/* sim/second_stage_speed_switch_tb.sv */
// self-checking bench of the second stage switch
`timescale 1ns/1ps
module second_stage_speed_switch_tb;
  import sss_pkg::*;
  localparam int UPD = 8;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [15:0] rpm = 16'h0;
  logic        fault = 1'h0, spk0 = 1'h0, spk1 = 1'h0, mag = 1'h0, v;
  logic        awready, wready, bvalid, arready, rvalid, irq, so, soe_n, pin;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  disp_s       display;
  int          num_errors = 0, n_checks = 0;
  always #20 clock = ~clock;
  second_stage_speed_switch #(.STEP_CYCLES(20), .UPDATE_CYCLES(UPD)) second_stage_speed_switch_i (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .engine_rpm(rpm), .fault_present(fault), .spark_zero(spk0), .spark_half(spk1),
    .magnet_pin(mag), .display(display), .stage_i(pin), .stage_o(so),
    .stage_oe_n(soe_n), .irq(irq));
  load_model load_model_i (.stage_o(so), .stage_oe_n(soe_n), .pin_level(pin));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task finish_test;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task hang(input string nm);
    num_errors++;
    $display("mismatch %s expected answer seen none", nm);
    finish_test();
  endtask
  // ---------------------------------------------------------------
  // bus, magnet and display helpers
  // ---------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    rsp = bresp;
    if (i == 50) hang("write");
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a);
    int i;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    rd_v = rdata;
    rsp = rresp;
    if (i == 50) hang("read");
    @(posedge clock);
  endtask
  task press;
    mag <= 1'h1;
    repeat (6) @(posedge clock);
    mag <= 1'h0;
    repeat (6) @(posedge clock);
  endtask
  task tick;
    repeat (2 * UPD + 3) @(posedge clock);
  endtask
  // mask selects which of tens and ones must match
  task wait_disp(input disp_e k, input logic [7:0] val, input logic [7:0] m);
    int i;
    n_checks++;
    for (i = 0; i < 4000; i++) begin
      @(posedge clock);
      if (display.kind === k && ((({display.tens, display.ones} ^ val) & m) === 8'h00)) break;
    end
    if (i == 4000) hang("display");
  endtask
  task menu3(input logic [3:0] shown, input logic [3:0] d1, input disp_e fin);
    wait_disp(DK_BLANK, 8'h00, 8'h00);
    wr(8'h00, 32'h3);
    wait_disp(DK_MODE, 8'h05, 8'h0F);
    wait_disp(DK_MODE, 8'h03, 8'h0F);
    press();
    wait_disp(DK_DIGITS, {4'h0, shown}, 8'hFF);
    wait_disp(DK_READY, 8'h00, 8'h00);
    wait_disp(DK_SELECT, 8'h00, 8'h0F);
    press();
    wait_disp(DK_DIGITS, 8'h05, 8'hFF);
    wait_disp(DK_DIGITS, 8'h00, 8'hFF);
    press();
    wait_disp(DK_DIGITS, {4'h1, d1}, 8'hFF);
    press();
    wait_disp(DK_DIGITS, 8'h20, 8'hFF);
    press();
    wait_disp(fin, 8'h00, 8'h00);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'h1;
    rd(8'h08);
    chk("thresh", rd_v, 32'h0064_0032);
    rd(8'h18);
    chk("rresp", 32'(rsp), 32'h2);
    wr(8'h18, 32'h1);
    chk("bresp", 32'(rsp), 32'h2);
    wr(8'h14, 32'h7);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h1);
    spk0 <= 1'h1;
    repeat (3) @(posedge clock);
    chk("oe_zero", 32'(soe_n), 32'h0);
    spk0 <= 1'h0;
    wr(8'h04, 32'h2);
    spk1 <= 1'h1;
    repeat (3) @(posedge clock);
    chk("oe_half", 32'(soe_n), 32'h0);
    spk1 <= 1'h0;
    wr(8'h04, 32'h3);
    rd(8'h04);
    chk("mode", rd_v, 32'h2);
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h3);
    rpm <= 16'd5000;
    tick();
    chk("oe_at_lo", 32'(soe_n), 32'h1);
    wr(8'h10, 32'h7);
    rpm <= 16'd5001;
    tick();
    chk("oe_above_lo", 32'(soe_n), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    chk("stage_o", 32'(so), 32'h0);
    rd(8'h0C);
    chk("status_on", rd_v, 32'h1);
    wr(8'h14, 32'h0);
    repeat (2) @(posedge clock);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(8'h14, 32'h7);
    wr(8'h10, 32'h4);
    repeat (2) @(posedge clock);
    chk("irq_cleared", 32'(irq), 32'h0);
    rpm <= 16'd10001;
    tick();
    chk("oe_above_hi", 32'(soe_n), 32'h1);
    wr(8'h04, 32'h4);
    fault <= 1'h1;
    tick();
    chk("oe_fault", 32'(soe_n), 32'h0);
    fault <= 1'h0;
    tick();
    chk("oe_no_fault", 32'(soe_n), 32'h1);
    wr(8'h04, 32'h5);
    fault <= 1'h1;
    tick();
    v = soe_n;
    repeat (UPD) @(posedge clock);
    chk("blink_a", 32'(soe_n), {31'h0, ~v});
    repeat (UPD) @(posedge clock);
    chk("blink_b", 32'(soe_n), 32'(v));
    fault <= 1'h0;
    wr(8'h10, 32'h7);
    wr(8'h00, 32'h3);
    wait_disp(DK_MODE, 8'h04, 8'h0F);
    press();
    wait_disp(DK_STORED, 8'h00, 8'h00);
    rd(8'h04);
    chk("mode_pick", rd_v, 32'h4);
    menu3(4'h5, 4'h6, DK_STORED);
    rd(8'h08);
    chk("thresh_new", rd_v, 32'h0064_003C);
    menu3(4'h6, 4'h0, DK_ERROR);
    rd(8'h08);
    chk("thresh_kept", rd_v, 32'h0064_003C);
    rd(8'h10);
    chk("err_event", rd_v & 32'h2, 32'h2);
    finish_test();
  end
endmodule // second_stage_speed_switch_tb
